/* rtl/dls_pkg.sv */
// package: register map, reset values, limits and carriers of the d-channel link supervisor
package dls_pkg;
   // ----------------------------------------
   // clock and time base
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int HALF_SEC_NS = 500000000;
   localparam int HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 7;
   localparam logic [TIMER_W-1:0] HALVES_PER_SEC = 7'h02;
   localparam logic [TIMER_W-1:0] INTERVAL_HALVES = 7'h0a;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_ACK_WAIT = 8'h00;
   localparam logic [7:0] ADDR_IDLE_PROBE = 8'h04;
   localparam logic [7:0] ADDR_RETRY_LIMIT = 8'h08;
   localparam logic [7:0] ADDR_MAX_INFO = 8'h0c;
   localparam logic [7:0] ADDR_WINDOW = 8'h10;
   localparam logic [7:0] ADDR_MSG_THRESH = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
   localparam logic [7:0] ADDR_MSG_COUNT = 8'h24;

   // ----------------------------------------
   // limits and reset values
   // ----------------------------------------
   localparam logic [5:0] ACK_WAIT_MIN = 6'h02;
   localparam logic [5:0] ACK_WAIT_MAX = 6'h28;
   localparam logic [5:0] ACK_WAIT_RST = 6'h03;
   localparam logic [5:0] IDLE_MIN = 6'h02;
   localparam logic [5:0] IDLE_MAX = 6'h28;
   localparam logic [5:0] IDLE_RST = 6'h0a;
   localparam logic [3:0] RETRY_MIN = 4'h1;
   localparam logic [3:0] RETRY_MAX = 4'h8;
   localparam logic [3:0] RETRY_RST = 4'h3;
   localparam logic [8:0] INFO_MIN = 9'h004;
   localparam logic [8:0] INFO_MAX = 9'h104;
   localparam logic [2:0] WIN_MIN = 3'h1;
   localparam logic [2:0] WIN_MAX = 3'h7;
   localparam logic [8:0] THR_MIN = 9'h03c;
   localparam logic [8:0] THR_MAX = 9'h15e;
   localparam logic [8:0] THR_RST = 9'h12c;

   // ----------------------------------------
   // interrupt event bits
   // ----------------------------------------
   localparam int IRQ_W = 6;
   localparam int EV_RETX = 0;
   localparam int EV_RECOVER = 1;
   localparam int EV_PROBE = 2;
   localparam int EV_WARN = 3;
   localparam int EV_REJECT = 4;
   localparam int EV_OVERSIZE = 5;

   typedef struct packed {
      logic [5:0] ack_wait;
      logic [5:0] idle_probe;
      logic [3:0] retry_limit;
      logic [8:0] max_info_octets;
      logic [2:0] window;
      logic [8:0] call_msg_threshold;
   } dls_cfg_t;

   typedef struct packed {
      logic over_prev;
      logic rejecting;
      logic [3:0] retry;
      logic [3:0] outstanding;
   } dls_status_t;

   localparam dls_cfg_t CFG_RST = '{ACK_WAIT_RST, IDLE_RST, RETRY_RST, INFO_MAX, WIN_MAX, THR_RST};

   typedef enum logic [1:0] {
      CALL_OPEN = 2'b01,
      CALL_SHUT = 2'b10
   } dls_call_state_t;
endpackage

/* rtl/dls_tick.sv */
// half-second tick divider
`timescale 1ns/1ps
module dls_tick #(
   parameter int CYCLES = 62500000
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   output logic tick_o
);
   logic [31:0] cnt_q;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_q <= 32'h0;
         tick_o <= 1'b0;
      end
      else if (cnt_q >= 32'(CYCLES - 1))
      begin
         cnt_q <= 32'h0;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule

/* rtl/dls_timer.sv */
// down counter in half-second ticks with one-cycle expiry pulse
`timescale 1ns/1ps
module dls_timer #(
   parameter int W = 7
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic tick_i,
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   input wire logic stop_i,
   output logic run_o,
   output logic expire_o
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_q <= '0;
         run_o <= 1'b0;
         expire_o <= 1'b0;
      end
      else
      begin
         expire_o <= 1'b0;
         if (load_i)
         begin
            // zero would wrap round the whole counter before it expires, so treat it as one tick
            cnt_q <= (value_i == '0) ? W'(1) : value_i;
            run_o <= 1'b1;
         end
         else if (stop_i)
            run_o <= 1'b0;
         else if (tick_i && run_o)
         begin
            if (cnt_q == W'(1))
            begin
               run_o <= 1'b0;
               expire_o <= 1'b1;
            end
            else
               cnt_q <= cnt_q - W'(1);
         end
      end
   end
endmodule

/* rtl/dls_supervisor.sv */
// d-channel link supervisor: ack-wait retry, idle probe, window, frame size, call overload policing
`timescale 1ns/1ps
module dls_supervisor
   import dls_pkg::*;
#(
   parameter int TICK_CYCLES = HALF_SEC_CYCLES
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   input wire logic TX_FRAME_I,
   input wire logic [8:0] TX_LEN_I,
   input wire logic ACK_I,
   input wire logic [2:0] ACK_CNT_I,
   input wire logic RX_FRAME_I,
   input wire logic L3_MSG_I,
   input wire logic CALL_REQ_I,
   output logic TX_ALLOW_O,
   output logic RETX_REQ_O,
   output logic RR_REQ_O,
   output logic LINK_RECOVER_O,
   output logic WARN_O,
   output logic CALL_ACCEPT_O,
   output logic CALL_REJECT_O,
   output logic IRQ_O
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   dls_cfg_t cfg_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, ev;
   logic [3:0] out_q, out_d, retry_q, acked;
   logic [8:0] msg_cnt_q;
   logic over_prev_q, reject_q, tick;
   logic ack_run, ack_exp, idle_run, idle_exp, int_run, int_exp;
   logic tx_ok, oversize, ack_load, ack_stop, over, reject_next;
   dls_call_state_t call_q;
   dls_status_t status;

   function automatic logic [8:0] clamp(input logic [31:0] v, input logic [8:0] lo, input logic [8:0] hi);
      if (v < {23'h0, lo})
         return lo;
      else if (v > {23'h0, hi})
         return hi;
      else
         return v[8:0];
   endfunction

   // ----------------------------------------
   // time base and timers
   // ----------------------------------------
   dls_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .tick_o(tick)
   );

   dls_timer #(.W(TIMER_W)) u_ack (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .tick_i(tick),
      .load_i(ack_load),
      .value_i({1'b0, cfg_q.ack_wait}),
      .stop_i(ack_stop),
      .run_o(ack_run),
      .expire_o(ack_exp)
   );

   // idle period is in seconds, the timer counts half seconds
   dls_timer #(.W(TIMER_W)) u_idle (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .tick_i(tick),
      .load_i(RX_FRAME_I || !idle_run),
      .value_i(TIMER_W'({1'b0, cfg_q.idle_probe} * HALVES_PER_SEC)),
      .stop_i(1'b0),
      .run_o(idle_run),
      .expire_o(idle_exp)
   );

   dls_timer #(.W(TIMER_W)) u_interval (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .tick_i(tick),
      .load_i(!int_run),
      .value_i(INTERVAL_HALVES),
      .stop_i(1'b0),
      .run_o(int_run),
      .expire_o(int_exp)
   );

   // ----------------------------------------
   // window and frame size
   // ----------------------------------------
   assign oversize = TX_FRAME_I && (TX_LEN_I > cfg_q.max_info_octets);
   assign tx_ok = TX_FRAME_I && !oversize && (out_q < {1'b0, cfg_q.window});
   assign acked = ({1'b0, ACK_CNT_I} > out_q) ? out_q : {1'b0, ACK_CNT_I};

   always_comb
   begin
      out_d = out_q;
      if (ACK_I)
         out_d = out_d - acked;
      if (tx_ok)
         out_d = out_d + 4'h1;
      if (ack_exp && !(ACK_I && acked != 4'h0) && retry_q >= cfg_q.retry_limit)
         out_d = 4'h0;
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         out_q <= 4'h0;
         TX_ALLOW_O <= 1'b1;
      end
      else
      begin
         out_q <= out_d;
         // stays low until an acknowledgment, a link recovery or a wider window write frees a slot
         TX_ALLOW_O <= out_d < {1'b0, cfg_q.window};
      end
   end

   // ----------------------------------------
   // ack wait and retransmission
   // ----------------------------------------
   // one timer guards the oldest outstanding frame
   assign ack_load = (tx_ok && !ack_run) || (ACK_I && out_d != 4'h0)
      || (ack_exp && retry_q < cfg_q.retry_limit);
   assign ack_stop = ACK_I && out_d == 4'h0;

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         retry_q <= 4'h0;
         RETX_REQ_O <= 1'b0;
         LINK_RECOVER_O <= 1'b0;
      end
      else
      begin
         RETX_REQ_O <= 1'b0;
         LINK_RECOVER_O <= 1'b0;
         if (ACK_I && acked != 4'h0)
            retry_q <= 4'h0;
         else if (ack_exp && retry_q < cfg_q.retry_limit)
         begin
            retry_q <= retry_q + 4'h1;
            RETX_REQ_O <= 1'b1;
         end
         else if (ack_exp)
         begin
            retry_q <= 4'h0;
            LINK_RECOVER_O <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         RR_REQ_O <= 1'b0;
      else
         RR_REQ_O <= idle_exp;
   end

   // ----------------------------------------
   // call-control overload policing
   // ----------------------------------------
   assign over = msg_cnt_q > cfg_q.call_msg_threshold;
   assign reject_next = over && over_prev_q && !reject_q;

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         msg_cnt_q <= 9'h0;
         over_prev_q <= 1'b0;
         reject_q <= 1'b0;
         WARN_O <= 1'b0;
      end
      else
      begin
         WARN_O <= int_exp && over;
         if (int_exp)
         begin
            msg_cnt_q <= {8'h0, L3_MSG_I};
            // history restarts when a rejection interval begins
            over_prev_q <= over && !reject_next;
            reject_q <= reject_next;
         end
         else if (L3_MSG_I && msg_cnt_q != 9'h1ff)
            msg_cnt_q <= msg_cnt_q + 9'h1;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         call_q <= CALL_OPEN;
         CALL_ACCEPT_O <= 1'b0;
         CALL_REJECT_O <= 1'b0;
      end
      else
      begin
         call_q <= reject_q ? CALL_SHUT : CALL_OPEN;
         CALL_ACCEPT_O <= 1'b0;
         CALL_REJECT_O <= 1'b0;
         case (call_q)
            CALL_OPEN: CALL_ACCEPT_O <= CALL_REQ_I && !reject_q;
            CALL_SHUT: CALL_REJECT_O <= CALL_REQ_I && reject_q;
            default: CALL_REJECT_O <= CALL_REQ_I;
         endcase
         if (call_q == CALL_OPEN && reject_q)
            CALL_REJECT_O <= CALL_REQ_I;
         if (call_q == CALL_SHUT && !reject_q)
            CALL_ACCEPT_O <= CALL_REQ_I;
      end
   end

   // ----------------------------------------
   // register port and interrupt
   // ----------------------------------------
   assign ev = {oversize, reject_next && int_exp, WARN_O, RR_REQ_O, LINK_RECOVER_O, RETX_REQ_O};
   assign status = '{over_prev_q, reject_q, retry_q, out_q};

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         cfg_q <= CFG_RST;
      else if (WR_I)
      begin
         // out-of-range writes are clamped to the nearest legal value
         case (ADDR_I)
            ADDR_ACK_WAIT: cfg_q.ack_wait <= 6'(clamp(WDATA_I, 9'(ACK_WAIT_MIN), 9'(ACK_WAIT_MAX)));
            ADDR_IDLE_PROBE: cfg_q.idle_probe <= 6'(clamp(WDATA_I, 9'(IDLE_MIN), 9'(IDLE_MAX)));
            ADDR_RETRY_LIMIT: cfg_q.retry_limit <= 4'(clamp(WDATA_I, 9'(RETRY_MIN), 9'(RETRY_MAX)));
            ADDR_MAX_INFO: cfg_q.max_info_octets <= clamp(WDATA_I, INFO_MIN, INFO_MAX);
            ADDR_WINDOW: cfg_q.window <= 3'(clamp(WDATA_I, 9'(WIN_MIN), 9'(WIN_MAX)));
            ADDR_MSG_THRESH: cfg_q.call_msg_threshold <= clamp(WDATA_I, THR_MIN, THR_MAX);
            default: cfg_q <= cfg_q;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         IRQ_O <= 1'b0;
      end
      else
      begin
         // a new event wins over a clear in the same cycle
         if (WR_I && ADDR_I == ADDR_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~WDATA_I[IRQ_W-1:0]) | ev;
         else
            irq_stat_q <= irq_stat_q | ev;
         if (WR_I && ADDR_I == ADDR_IRQ_MASK)
            irq_mask_q <= WDATA_I[IRQ_W-1:0];
         IRQ_O <= |(irq_stat_q & irq_mask_q);
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         RDATA_O <= 32'h0;
      else if (RD_I)
      begin
         case (ADDR_I)
            ADDR_ACK_WAIT: RDATA_O <= {26'h0, cfg_q.ack_wait};
            ADDR_IDLE_PROBE: RDATA_O <= {26'h0, cfg_q.idle_probe};
            ADDR_RETRY_LIMIT: RDATA_O <= {28'h0, cfg_q.retry_limit};
            ADDR_MAX_INFO: RDATA_O <= {23'h0, cfg_q.max_info_octets};
            ADDR_WINDOW: RDATA_O <= {29'h0, cfg_q.window};
            ADDR_MSG_THRESH: RDATA_O <= {23'h0, cfg_q.call_msg_threshold};
            ADDR_STATUS: RDATA_O <= {22'h0, status};
            ADDR_IRQ_STAT: RDATA_O <= {26'h0, irq_stat_q};
            ADDR_IRQ_MASK: RDATA_O <= {26'h0, irq_mask_q};
            ADDR_MSG_COUNT: RDATA_O <= {23'h0, msg_cnt_q};
            default: RDATA_O <= 32'h0;
         endcase
      end
      else
         RDATA_O <= 32'h0;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   retx_on_expiry_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ack_exp && !ACK_I && retry_q < cfg_q.retry_limit |=> RETX_REQ_O && !LINK_RECOVER_O)
      else $error("no retransmit after ack wait expiry");
   recover_after_limit_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ack_exp && !ACK_I && retry_q >= cfg_q.retry_limit |=> LINK_RECOVER_O && !RETX_REQ_O && retry_q == 4'h0)
      else $error("no link recovery after retries");
   ack_wait_range_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      cfg_q.ack_wait >= ACK_WAIT_MIN && cfg_q.ack_wait <= ACK_WAIT_MAX)
      else $error("ack wait out of range");
   idle_probe_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      idle_exp |=> RR_REQ_O ##1 !RR_REQ_O)
      else $error("idle expiry gave no single probe");
   idle_restart_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      RX_FRAME_I |=> idle_run ##1 !RR_REQ_O)
      else $error("receive did not restart idle timer");
   limits_range_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      cfg_q.retry_limit inside {[RETRY_MIN:RETRY_MAX]} && cfg_q.max_info_octets inside {[INFO_MIN:INFO_MAX]})
      else $error("retry or size limit out of range");
   window_full_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      out_q >= {1'b0, cfg_q.window} |=> out_q <= $past(out_q))
      else $error("frame sent past full window");
   ack_clears_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ACK_I && ACK_CNT_I != 3'h0 && out_q != 4'h0 |=> retry_q == 4'h0 && !RETX_REQ_O)
      else $error("ack did not clear retry count");
   warn_on_over_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      int_exp && msg_cnt_q > cfg_q.call_msg_threshold |=> WARN_O)
      else $error("overload warning missing");
   reject_third_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      CALL_REQ_I && reject_q |=> CALL_REJECT_O && !CALL_ACCEPT_O)
      else $error("call accepted during rejection");
   resume_accept_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      int_exp && reject_q |=> !reject_q)
      else $error("rejection lasted past one interval");
endmodule

/* test/dls_peer.sv */
// peer data-link model: acknowledges, polls and answers probes on the far side of the link
`timescale 1ns/1ps
module dls_peer
   import dls_pkg::*;
#(
   parameter int ACK_DELAY = 3
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ack_en_i,
   input wire logic poll_i,
   input wire logic [8:0] max_len_i,
   input wire logic tx_frame_i,
   input wire logic [8:0] tx_len_i,
   input wire logic tx_allow_i,
   input wire logic recover_i,
   input wire logic rr_req_i,
   output logic ack_o,
   output logic [2:0] ack_cnt_o,
   output logic rx_frame_o
);
   // ----------------------------------------
   // frames held by the peer
   // ----------------------------------------
   logic [3:0] pend_q;
   logic [3:0] wait_q;
   logic [2:0] poll_q;
   logic take;
   logic fire;
   // same window as the device: only frames it let out count
   assign take = tx_frame_i && tx_allow_i && (tx_len_i <= max_len_i);
   assign fire = ack_en_i && (pend_q != 4'h0) && (wait_q == 4'(ACK_DELAY));
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pend_q <= 4'h0;
         wait_q <= 4'h0;
         poll_q <= 3'h0;
         ack_o <= 1'b0;
         ack_cnt_o <= 3'h0;
         rx_frame_o <= 1'b0;
      end
      else
      begin
         // link reset on recovery drops what the peer still held
         pend_q <= recover_i ? 4'h0 : ((fire ? 4'h0 : pend_q) + 4'(take));
         wait_q <= (fire || !ack_en_i || pend_q == 4'h0) ? 4'h0 : wait_q + 4'h1;
         poll_q <= poll_q + 3'h1;
         ack_o <= fire;
         // count line carries garbage outside an ack, never the last value
         ack_cnt_o <= fire ? pend_q[2:0] : ~ack_cnt_o;
         rx_frame_o <= fire || rr_req_i || (poll_i && poll_q == 3'h0);
      end
   end
endmodule

/* test/test_dls_supervisor.sv */
// testbench of the d-channel link supervisor against the peer model
`timescale 1ns/1ps
module test_dls_supervisor
   import dls_pkg::*;
;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam int TICK = 8;
   localparam logic [7:0] RA [7] = '{ADDR_ACK_WAIT, ADDR_IDLE_PROBE, ADDR_RETRY_LIMIT, ADDR_MAX_INFO, ADDR_WINDOW,
      ADDR_MSG_THRESH, 8'h28};
   localparam int RV [7] = '{3, 'ha, 3, 'h104, 7, 'h12c, 0};
   localparam int CW [12] = '{1, 'h29, 1, 'h29, 0, 9, 3, 'h105, 0, 8, 'h3b, 'h15f};
   localparam int CE [12] = '{2, 'h28, 2, 'h28, 1, 8, 4, 'h104, 1, 7, 'h3c, 'h15e};
   logic clk;
   logic nrst_n;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic bus_wr;
   logic bus_rd;
   logic [31:0] rdata;
   logic tx;
   logic [8:0] len;
   logic ack;
   logic [2:0] ack_cnt;
   logic rx;
   logic msg;
   logic call;
   logic allow;
   logic retx;
   logic rr;
   logic rec;
   logic warn;
   logic acc;
   logic rej;
   logic irq;
   logic ack_en;
   logic poll;
   logic [8:0] max_len;
   int n_errors;
   int compares;
   int cyc;
   dls_supervisor #(.TICK_CYCLES(TICK)) dls_supervisor_i (.CLK_I(clk), .NRST_I(nrst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(bus_wr), .RD_I(bus_rd), .RDATA_O(rdata), .TX_FRAME_I(tx), .TX_LEN_I(len),
      .ACK_I(ack), .ACK_CNT_I(ack_cnt), .RX_FRAME_I(rx), .L3_MSG_I(msg), .CALL_REQ_I(call), .TX_ALLOW_O(allow),
      .RETX_REQ_O(retx), .RR_REQ_O(rr), .LINK_RECOVER_O(rec), .WARN_O(warn), .CALL_ACCEPT_O(acc),
      .CALL_REJECT_O(rej), .IRQ_O(irq));
   dls_peer dls_peer_i (.clk_i(clk), .nrst_i(nrst_n), .ack_en_i(ack_en), .poll_i(poll), .max_len_i(max_len),
      .tx_frame_i(tx), .tx_len_i(len), .tx_allow_i(allow), .recover_i(rec), .rr_req_i(rr), .ack_o(ack),
      .ack_cnt_o(ack_cnt), .rx_frame_o(rx));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic send(input logic [8:0] l);
      @(posedge clk);
      tx <= 1'b1;
      len <= l;
      @(posedge clk);
      tx <= 1'b0;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] d;
      for (int i = 0; i < 7; i++)
      begin
         rd(RA[i], d);
         chk("reset value", 32'(RV[i]), d);
      end
      for (int i = 0; i < 12; i++)
      begin
         wr(RA[i / 2], 32'(CW[i]));
         rd(RA[i / 2], d);
         chk("clamped value", 32'(CE[i]), d);
      end
      for (int i = 0; i < 7; i++)
         wr(RA[i], 32'(RV[i]));
      rd(8'h28, d);
      chk("unmapped read", 32'h0, d);
      chk("allow after reset", 32'h1, 32'(allow));
      $display("test regs done");
   endtask
   task automatic t_retry();
      int n_retx = 0;
      int n_rec = 0;
      int first = 0;
      logic [31:0] d;
      wr(ADDR_RETRY_LIMIT, 32'h2);
      wr(ADDR_IRQ_STAT, 32'h3f);
      send(9'h010);
      for (int i = 1; i <= 150; i++)
      begin
         step();
         if (retx === 1'b1 && first == 0)
            first = i;
         n_retx += int'(retx === 1'b1);
         n_rec += int'(rec === 1'b1);
      end
      chk("first retransmit time", 32'h1, 32'(first >= 2 * TICK && first <= 3 * TICK + 2));
      chk("retransmit count", 32'h2, 32'(n_retx));
      chk("recovery count", 32'h1, 32'(n_rec));
      rd(ADDR_STATUS, d);
      chk("outstanding after recovery", 32'h0, 32'(d[3:0]));
      rd(ADDR_IRQ_STAT, d);
      chk("irq retx and recover", 32'h3, 32'(d[1:0]));
      wr(ADDR_IRQ_MASK, 32'h3);
      step();
      chk("irq raised", 32'h1, 32'(irq));
      wr(ADDR_IRQ_STAT, 32'h3);
      step();
      chk("irq cleared", 32'h0, 32'(irq));
      wr(ADDR_IRQ_MASK, 32'h0);
      wr(ADDR_RETRY_LIMIT, 32'h3);
      $display("test retry done");
   endtask
   task automatic t_window();
      int n_retx = 0;
      logic [31:0] d;
      wr(ADDR_WINDOW, 32'h2);
      @(posedge clk);
      tx <= 1'b1;
      len <= 9'h020;
      repeat (3) @(posedge clk);
      tx <= 1'b0;
      step();
      chk("allow at full window", 32'h0, 32'(allow));
      rd(ADDR_STATUS, d);
      chk("outstanding at window", 32'h2, 32'(d[3:0]));
      ack_en <= 1'b1;
      for (int i = 0; i < 20 && allow !== 1'b1; i++)
         step();
      chk("allow after ack", 32'h1, 32'(allow));
      rd(ADDR_STATUS, d);
      chk("status after ack", 32'h0, 32'(d[7:0]));
      repeat (60)
      begin
         step();
         n_retx += int'(retx === 1'b1);
      end
      chk("retransmit after ack", 32'h0, 32'(n_retx));
      ack_en <= 1'b0;
      wr(ADDR_WINDOW, 32'h7);
      $display("test window done");
   endtask
   task automatic t_size(input logic [8:0] lim);
      logic [31:0] d;
      wr(ADDR_MAX_INFO, 32'(lim));
      max_len <= lim;
      wr(ADDR_IRQ_STAT, 32'h3f);
      send(lim + 9'h001);
      send(lim);
      rd(ADDR_STATUS, d);
      chk("outstanding by size", 32'h1, 32'(d[3:0]));
      rd(ADDR_IRQ_STAT, d);
      chk("oversize irq", 32'h1, 32'(d[EV_OVERSIZE]));
      ack_en <= 1'b1;
      repeat (10) step();
      ack_en <= 1'b0;
      wr(ADDR_MAX_INFO, 32'h104);
      max_len <= 9'h104;
      $display("test size done");
   endtask
   task automatic t_idle();
      int n_rr = 0;
      int at = 0;
      wr(ADDR_IDLE_PROBE, 32'h2);
      poll <= 1'b1;
      repeat (100)
      begin
         step();
         n_rr += int'(rr === 1'b1);
      end
      chk("probe while traffic", 32'h0, 32'(n_rr));
      poll <= 1'b0;
      for (int i = 1; i <= 60 && at == 0; i++)
      begin
         step();
         if (rr === 1'b1)
            at = i;
      end
      // two seconds are four ticks; the last poll frame lands up to a tick before release
      chk("probe time", 32'h1, 32'(at >= 2 * TICK && at <= 4 * TICK + 2));
      wr(ADDR_IDLE_PROBE, 32'ha);
      $display("test idle done");
   endtask
   task automatic iv(input int n, input int w_exp, input int c_exp);
      int w = 0;
      logic a = 1'b0;
      logic r = 1'b0;
      for (int i = 0; i < 80; i++)
      begin
         @(posedge clk);
         msg <= (i < n);
         call <= (i == 70);
         #1;
         w += int'(warn === 1'b1);
         if (i == 71)
         begin
            a = acc;
            r = rej;
         end
      end
      chk("warning count", 32'(w_exp), 32'(w));
      chk("call accept", 32'(c_exp == 1), 32'(a));
      chk("call reject", 32'(c_exp == 2), 32'(r));
   endtask
   task automatic t_overload();
      logic [31:0] d;
      wr(ADDR_MSG_THRESH, 32'h3c);
      @(posedge clk);
      msg <= 1'b1;
      for (int i = 0; i < 250 && warn !== 1'b1; i++)
         step();
      @(posedge clk);
      msg <= 1'b0;
      // interval phase is now known from the warning edge
      iv(0, 0, 1);
      iv(60, 0, 1);
      iv(61, 1, 1);
      iv(61, 1, 1);
      iv(0, 0, 2);
      iv(0, 0, 1);
      // a fresh interval has just begun, so five messages stay in one count
      @(posedge clk);
      msg <= 1'b1;
      repeat (5) @(posedge clk);
      msg <= 1'b0;
      rd(ADDR_MSG_COUNT, d);
      chk("message count", 32'h5, d);
      rd(ADDR_IRQ_STAT, d);
      chk("irq probe warn reject", 32'h7, 32'(d[4:2]));
      wr(ADDR_MSG_THRESH, 32'h12c);
      $display("test overload done");
   endtask
   // ----------------------------------------
   // clock, reset, timeout and sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_errors++;
         end_sim();
      end
   end
   initial
   begin
      {nrst_n, bus_wr, bus_rd, tx, msg, call, ack_en, poll} = '0;
      addr = 8'h00;
      wdata = 32'h0;
      len = 9'h000;
      max_len = 9'h104;
      n_errors = 0;
      compares = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      nrst_n <= 1'b1;
      t_regs();
      t_retry();
      t_window();
      t_size(9'h004);
      t_size(9'h104);
      t_idle();
      t_overload();
      end_sim();
   end
endmodule
